// ---- dv/bsc_host_model.sv ----
/* bsc_host_model: host software on the register port.
   assumes one clock shared with bsc_top. */
`timescale 1ns/1ps
`default_nettype none
module bsc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  ////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // stale data must not look valid
    wdata_o <= ~d;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd
endmodule : bsc_host_model
`default_nettype wire

// ---- dv/bsc_top_chk.sv ----
/* bsc_top_chk: port assertions for bsc_top.
   assumes the bind below reaches every bsc_top. */
`timescale 1ns/1ps
`default_nettype none
module bsc_top_chk
  import bsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cfg_range_high_i,
  input wire bsc_op_type op_mode_i,
  input wire logic [5:0] active_code_o,
  input wire logic active_range_high_o,
  input wire logic [11:0] target_mv_o,
  input wire logic [3:0] switching_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////
  property p_low;
    !active_range_high_o |-> target_mv_o == 12'h190 + 12'h019 * active_code_o;
  endproperty
  a_low: assert property (p_low) else $error("low target");
  property p_high;
    active_range_high_o |-> target_mv_o == 12'h320 + 12'h032 * active_code_o;
  endproperty
  a_high: assert property (p_high) else $error("high target");
  property p_sel;
    reg_wr_i && reg_addr_i == 8'h35 + 8'(op_mode_i) && 8'(op_mode_i) < 8'h03
      ##1 !reg_wr_i && $stable(op_mode_i) |=> active_code_o == $past(reg_wdata_i[5:0], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("code select");
  // range read skips the load edge
  property p_ro;
    reg_rd_i && reg_addr_i inside {8'h35, 8'h36, 8'h37} && !$past(reset_i)
      |=> reg_rdata_o[7:6] == {1'b0, active_range_high_o};
  endproperty
  a_ro: assert property (p_ro) else $error("range read");
  // loaded range reaches the output two edges after release, so skip three
  property p_keep;
    !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3)
      |-> $stable(active_range_high_o);
  endproperty
  a_keep: assert property (p_keep) else $error("range moved");
  property p_mode;
    reg_wr_i && reg_addr_i == 8'h38 |=> switching_mode_o == $past(reg_wdata_i[3:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode write");
  property p_mrd;
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'h38 |=> reg_rdata_o == {4'h0, switching_mode_o};
  endproperty
  a_mrd: assert property (p_mrd) else $error("mode read");
  c_high: cover property (active_range_high_o);
  c_sleep: cover property (op_mode_i == BSC_OP_SLEEP && reg_wr_i);
  c_mode: cover property (reg_wr_i && reg_addr_i == 8'h38);
endmodule : bsc_top_chk
bind bsc_top bsc_top_chk u_chk (.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .cfg_range_high_i, .op_mode_i, .active_code_o,
  .active_range_high_o, .target_mv_o, .switching_mode_o);
`default_nettype wire

// ---- dv/bsc_top_tb_top.sv ----
/* bsc_top_tb_top: self-checking bench for bsc_top.
   assumes the host model owns the register port. */
`timescale 1ns/1ps
`default_nettype none
module bsc_top_tb_top;
  import bsc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfg = 1'b0;
  bsc_op_type op = BSC_OP_NORMAL;
  logic wr, rd, rng;
  logic [7:0] addr, wdata, rdata, d;
  logic [5:0] code;
  logic [11:0] mv;
  logic [3:0] mode;
  int errors = 0;
  int n_compared = 0;
  // range, mode, code, target mV
  // targets above 0.6 V, high range from 2.0 V
  logic [20:0] rows [6] = '{{1'b0, 2'h0, 6'h09, 12'h271}, {1'b0, 2'h1, 6'h3F, 12'h7B7},
    {1'b0, 2'h2, 6'h20, 12'h4B0}, {1'b1, 2'h0, 6'h18, 12'h7D0},
    {1'b1, 2'h1, 6'h32, 12'hCE4}, {1'b1, 2'h2, 6'h28, 12'hAF0}};
  always #2 clk = ~clk;
  bsc_top uut (.clk_i(clk), .reset_i(reset), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cfg_range_high_i(cfg),
    .op_mode_i(op), .active_code_o(code), .active_range_high_o(rng),
    .target_mv_o(mv), .switching_mode_o(mode));
  bsc_host_model h (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  ////////////////////
  task chk(input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task conclude;
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // range bit written inverted, must be ignored
  task run_pass(input logic r);
    @(posedge clk);
    reset <= 1'b1;
    cfg <= r;
    repeat (5) @(posedge clk);
    #1;
    chk(code, 6'h00);
    chk(mv, 12'h190);
    chk(mode, 4'h0);
    @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    cfg <= ~r;
    for (int i = 0; i < 6; i++)
      if (rows[i][20] == r)
      begin
        h.wr(8'h35 + 8'(rows[i][19:18]), {1'b1, ~r, rows[i][17:12]});
        op <= bsc_op_type'(rows[i][19:18]);
        @(posedge clk);
        #1;
        chk(code, rows[i][17:12]);
        chk(mv, rows[i][11:0]);
        chk(rng, r);
        h.rd(8'h35 + 8'(rows[i][19:18]), d);
        chk(d, {1'b0, r, rows[i][17:12]});
      end
  endtask : run_pass
  initial
  begin
    run_pass(1'b0);
    run_pass(1'b1);
    @(posedge clk);
    op <= bsc_op_type'(2'h3);
    repeat (2) @(posedge clk);
    #1;
    chk(code, 6'h18);
    h.wr(BSC_MODE_ADDR, 8'hF5);
    #1;
    chk(mode, 4'h5);
    h.rd(BSC_MODE_ADDR, d);
    chk(d, 8'h05);
    h.rd(8'h39, d);
    chk(d, 8'h00);
    conclude();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule : bsc_top_tb_top
`default_nettype wire

// ---- hdl/bsc_decode_if.sv ----
/*
  bsc_decode_if: carries a step code and range to the decoder and the voltage back.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface bsc_decode_if;
  import bsc_pkg::*;
  logic [BSC_CODE_W-1:0] code;
  logic range_high;
  logic [BSC_MV_W-1:0] mv;

  modport ctrl (output code, output range_high, input mv);
  modport dec (input code, input range_high, output mv);
endinterface : bsc_decode_if

`default_nettype wire

// ---- hdl/bsc_decoder.sv ----
/*
  bsc_decoder: turns a step code and range bit into a target voltage in millivolts.
  assumes its output is registered by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module bsc_decoder
  import bsc_pkg::*;
(
  bsc_decode_if.dec dec_if
);

  logic [BSC_MV_W-1:0] code_ext;

  assign code_ext = {{(BSC_MV_W-BSC_CODE_W){1'b0}}, dec_if.code};

  always_comb
  begin
    if (dec_if.range_high)
    begin
      // [RULE_03] high range steps
      dec_if.mv = BSC_MV_W'(BSC_HIGH_BASE_MV + code_ext * BSC_HIGH_STEP_MV);
    end
    else
    begin
      // [RULE_02] low range steps
      dec_if.mv = BSC_MV_W'(BSC_LOW_BASE_MV + code_ext * BSC_LOW_STEP_MV);
    end
  end

endmodule : bsc_decoder

`default_nettype wire

// ---- hdl/bsc_pkg.sv ----
/*
  bsc_pkg: constants and types shared by the buck set-point control block.
  assumes a byte-wide register port addressed by the regulator's register offsets.
*/
`default_nettype none

package bsc_pkg;

  localparam int unsigned BSC_ADDR_W = 8;
  localparam int unsigned BSC_DATA_W = 8;
  localparam int unsigned BSC_CODE_W = 6;
  localparam int unsigned BSC_MODE_W = 4;
  localparam int unsigned BSC_MV_W = 12;

  // register offsets
  localparam logic [7:0] BSC_NORMAL_ADDR = 8'h35;
  localparam logic [7:0] BSC_STANDBY_ADDR = 8'h36;
  localparam logic [7:0] BSC_SLEEP_ADDR = 8'h37;
  localparam logic [7:0] BSC_MODE_ADDR = 8'h38;

  // field positions
  localparam int unsigned BSC_CODE_LSB = 0;
  localparam int unsigned BSC_RANGE_BIT = 6;
  localparam int unsigned BSC_MODE_LSB = 0;

  // reset values
  localparam logic [5:0] BSC_CODE_RESET = 6'h00;
  localparam logic BSC_RANGE_RESET = 1'b0;
  localparam logic [3:0] BSC_MODE_RESET = 4'h0;
  localparam logic [7:0] BSC_RDATA_RESET = 8'h00;

  // decoded voltage in millivolts
  localparam logic [11:0] BSC_LOW_BASE_MV = 12'h190;
  localparam logic [11:0] BSC_LOW_STEP_MV = 12'h019;
  localparam logic [11:0] BSC_HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] BSC_HIGH_STEP_MV = 12'h032;

  typedef enum logic [1:0] {
    BSC_OP_NORMAL,
    BSC_OP_STANDBY,
    BSC_OP_SLEEP
  } bsc_op_type;

endpackage : bsc_pkg

`default_nettype wire

// ---- hdl/bsc_top.sv ----
/*
  bsc_top: set-point registers, range bits and switching mode of one buck output.
  assumes a same-clock byte register port from the host interface logic, a
  configuration range level that is stable around reset release, and an
  operating-mode input from the power control logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE_01] normal range bit read-only, from configuration
// [RULE_02] low range: 0.400 V plus 25 mV steps
// [RULE_03] high range: 0.800 V plus 50 mV steps
// [RULE_04] three step codes, chosen by operating mode
// [RULE_05] standby and sleep range copy normal range
// [RULE_06] software keeps high range for 2.0-3.3 V
// [RULE_07] software avoids outputs at or below 0.6 V
// [RULE_08] four-bit switching mode field provided
// [RULE_09] software uses codes 0-63 below 2.0 V
// [RULE_10] range bit writes ignored, code still written
module bsc_top
  import bsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [bsc_pkg::BSC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [bsc_pkg::BSC_DATA_W-1:0] reg_wdata_i,
  output logic [bsc_pkg::BSC_DATA_W-1:0] reg_rdata_o,
  input wire logic cfg_range_high_i,
  input wire bsc_pkg::bsc_op_type op_mode_i,
  output logic [bsc_pkg::BSC_CODE_W-1:0] active_code_o,
  output logic active_range_high_o,
  output logic [bsc_pkg::BSC_MV_W-1:0] target_mv_o,
  output logic [bsc_pkg::BSC_MODE_W-1:0] switching_mode_o
);

  import bsc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [BSC_CODE_W-1:0] normal_code_r;
  logic [BSC_CODE_W-1:0] standby_code_r;
  logic [BSC_CODE_W-1:0] sleep_code_r;
  logic normal_range_r;
  logic standby_range_r;
  logic sleep_range_r;
  logic range_loaded_r;
  logic [BSC_MODE_W-1:0] mode_r;
  logic [BSC_DATA_W-1:0] rdata_r;
  logic [BSC_DATA_W-1:0] rdata_nxt;
  logic [BSC_CODE_W-1:0] sel_code;
  logic sel_range;
  logic [BSC_CODE_W-1:0] active_code_r;
  logic active_range_r;
  logic [BSC_MV_W-1:0] target_mv_r;

  bsc_decode_if dec_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // step codes

  // [RULE_04] independent code writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      normal_code_r <= BSC_CODE_RESET;
      standby_code_r <= BSC_CODE_RESET;
      sleep_code_r <= BSC_CODE_RESET;
    end
    else if (reg_wr_i)
    begin
      // [RULE_10] code field still taken
      unique case (reg_addr_i)
        BSC_NORMAL_ADDR: normal_code_r <= reg_wdata_i[BSC_CODE_LSB +: BSC_CODE_W];
        BSC_STANDBY_ADDR: standby_code_r <= reg_wdata_i[BSC_CODE_LSB +: BSC_CODE_W];
        BSC_SLEEP_ADDR: sleep_code_r <= reg_wdata_i[BSC_CODE_LSB +: BSC_CODE_W];
        default:
        begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // range bits

  // the configuration level is caught after release, never under reset
  // [RULE_01] range from configuration only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      normal_range_r <= BSC_RANGE_RESET;
      range_loaded_r <= 1'b0;
    end
    else if (!range_loaded_r)
    begin
      normal_range_r <= cfg_range_high_i;
      range_loaded_r <= 1'b1;
    end
  end

  // [RULE_05] copy initial range
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      standby_range_r <= BSC_RANGE_RESET;
      sleep_range_r <= BSC_RANGE_RESET;
    end
    else if (!range_loaded_r)
    begin
      standby_range_r <= cfg_range_high_i;
      sleep_range_r <= cfg_range_high_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // switching mode

  // [RULE_08] switching mode field
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_r <= BSC_MODE_RESET;
    end
    else if (reg_wr_i && reg_addr_i == BSC_MODE_ADDR)
    begin
      mode_r <= reg_wdata_i[BSC_MODE_LSB +: BSC_MODE_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back

  // unmapped offsets and unused bits read as zero
  always_comb
  begin
    rdata_nxt = BSC_RDATA_RESET;
    unique case (reg_addr_i)
      BSC_NORMAL_ADDR:
      begin
        rdata_nxt[BSC_CODE_LSB +: BSC_CODE_W] = normal_code_r;
        rdata_nxt[BSC_RANGE_BIT] = normal_range_r;
      end
      BSC_STANDBY_ADDR:
      begin
        rdata_nxt[BSC_CODE_LSB +: BSC_CODE_W] = standby_code_r;
        rdata_nxt[BSC_RANGE_BIT] = standby_range_r;
      end
      BSC_SLEEP_ADDR:
      begin
        rdata_nxt[BSC_CODE_LSB +: BSC_CODE_W] = sleep_code_r;
        rdata_nxt[BSC_RANGE_BIT] = sleep_range_r;
      end
      BSC_MODE_ADDR:
      begin
        rdata_nxt[BSC_MODE_LSB +: BSC_MODE_W] = mode_r;
      end
      default:
      begin
      end
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_r <= BSC_RDATA_RESET;
    end
    else if (reg_rd_i)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // active set point

  // [RULE_04] select by operating mode
  always_comb
  begin
    unique case (op_mode_i)
      BSC_OP_NORMAL:
      begin
        sel_code = normal_code_r;
        sel_range = normal_range_r;
      end
      BSC_OP_STANDBY:
      begin
        sel_code = standby_code_r;
        sel_range = standby_range_r;
      end
      BSC_OP_SLEEP:
      begin
        sel_code = sleep_code_r;
        sel_range = sleep_range_r;
      end
      default:
      begin
        // an undefined mode code falls back to the normal set point
        sel_code = normal_code_r;
        sel_range = normal_range_r;
      end
    endcase
  end

  assign dec_bus.code = sel_code;
  assign dec_bus.range_high = sel_range;

  bsc_decoder u_decoder (
    .dec_if (dec_bus)
  );

  // one register stage keeps the target glitch-free toward the power stage
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      active_code_r <= BSC_CODE_RESET;
      active_range_r <= BSC_RANGE_RESET;
      target_mv_r <= BSC_LOW_BASE_MV;
    end
    else
    begin
      active_code_r <= sel_code;
      active_range_r <= sel_range;
      target_mv_r <= dec_bus.mv;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o = rdata_r;
  assign active_code_o = active_code_r;
  assign active_range_high_o = active_range_r;
  assign target_mv_o = target_mv_r;
  assign switching_mode_o = mode_r;

endmodule : bsc_top

`default_nettype wire
